// >>> odg_pkg.sv
// Function
// - Four causes disable the PWM timer outputs.
// - Trip input rising edge tristates group pins.
// - Trip input edge also raises an interrupt.
// - Oscillation stop tristates group pins.
// - Four sticky flags; clearing them releases pins.
// - Four independent groups, each own trip input.
package odg_pkg;
   localparam int unsigned GROUPS = 4;
   localparam int unsigned CHANNELS = 4;
   localparam int unsigned FLAGS = 4;
   localparam int unsigned FLAG_TRIP = 0;
   localparam int unsigned FLAG_REQ = 1;
   localparam int unsigned FLAG_OSC = 2;
   localparam int unsigned FLAG_SW = 3;
   localparam logic [11:0] ADDR_FLAGS = 12'h000;
   localparam logic [11:0] ADDR_CTRL = 12'h004;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
   localparam logic [11:0] ADDR_ASSOC = 12'h010;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [GROUPS-1:0] CTRL_EN_RESET = 4'h0;
   localparam logic [GROUPS-1:0] IRQ_MASK_RESET = 4'h0;
   localparam logic [CHANNELS-1:0] ASSOC_RESET = 4'hf;
   localparam int unsigned CTRL_SW_LSB = 8;
   localparam int unsigned CTRL_OSC_LSB = 16;
   localparam int unsigned CTRL_REQ_LSB = 24;
   localparam int unsigned ASSOC_STRIDE = 8;
endpackage

// >>> odg_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface odg_sync_if;
   logic [odg_pkg::GROUPS+1-1:0] raw;
   logic [odg_pkg::GROUPS+1-1:0] sync;
   modport src (output raw, input sync);
   modport dst (input raw, output sync);
endinterface
`default_nettype wire

// >>> odg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module odg_sync
   import odg_pkg::*;
(
   input wire logic clock, // System clock.
   input wire logic rst, // Asynchronous reset.
   input wire logic ce, // Clock enable.
   odg_sync_if.dst s // Raw pins in, synchronised out.
);
   logic [GROUPS:0] meta_q, meta_d, sync_q, sync_d;
   always_comb
   begin
      meta_d = ce ? s.raw : meta_q;
      sync_d = ce ? meta_q : sync_q;
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign s.sync = sync_q;
endmodule
`default_nettype wire

// >>> output_disable_group.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module output_disable_group
   import odg_pkg::*;
(
   input wire logic clock, // 200 MHz system clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [GROUPS-1:0] external_trip_input, // Trip pins, one per group.
   input wire logic osc_stop, // Oscillation stop from the clock generator.
   input wire logic [GROUPS-1:0] timer_req, // Timer or comparator disable request, same clock.
   input wire logic [CHANNELS-1:0] timer_output_a_drive, // Timer value for output A.
   input wire logic [CHANNELS-1:0] timer_output_b_drive, // Timer value for output B.
   output logic [CHANNELS-1:0] timer_output_a, // Pin A value.
   output logic [CHANNELS-1:0] timer_output_a_oe_n, // Pin A enable, low drives.
   output logic [CHANNELS-1:0] timer_output_b, // Pin B value.
   output logic [CHANNELS-1:0] timer_output_b_oe_n, // Pin B enable, low drives.
   output logic irq // Level interrupt.
);
   odg_sync_if sif ();
   assign sif.raw = {osc_stop, external_trip_input};
   odg_sync u_sync (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .s(sif)
   );

   function automatic logic [GROUPS-1:0] w1c(input logic [GROUPS-1:0] cur, input logic [GROUPS-1:0] set,
                                              input logic [GROUPS-1:0] clr);
      // Set wins over a clear in the same cycle so no event is lost.
      w1c = set | (cur & ~clr);
   endfunction

   logic [GROUPS-1:0] trip_prev_q, trip_prev_d;
   logic [GROUPS-1:0] flag_q [FLAGS];
   logic [GROUPS-1:0] flag_d [FLAGS];
   logic [GROUPS-1:0] set_v [FLAGS];
   logic [31:0] ctrl_q, ctrl_d;
   logic [GROUPS-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
   logic [31:0] assoc_q, assoc_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [CHANNELS-1:0] oa_q, oa_d, ob_q, ob_d, oea_q, oea_d, oeb_q, oeb_d;
   logic irq_q, irq_d;
   logic [GROUPS-1:0] trip_now, trip_edge, grp_off;
   logic wr, rd;

   assign wr = psel && !penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign trip_now = sif.sync[GROUPS-1:0];
   assign trip_edge = trip_now & ~trip_prev_q & ctrl_q[GROUPS-1:0];

   always_comb
   begin
      logic hit;
      logic [GROUPS-1:0] clr;
      hit = 1'b0;
      clr = '0;
      trip_prev_d = trip_now;
      ctrl_d = ctrl_q;
      irq_mask_d = irq_mask_q;
      assoc_d = assoc_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      set_v[FLAG_TRIP] = trip_edge;
      set_v[FLAG_REQ] = timer_req & ctrl_q[CTRL_REQ_LSB +: GROUPS];
      set_v[FLAG_OSC] = {GROUPS{sif.sync[GROUPS]}} & ctrl_q[CTRL_OSC_LSB +: GROUPS];
      set_v[FLAG_SW] = '0;
      if (psel && !penable)
      begin
         pready_d = 1'b1;
         unique case (paddr)
            ADDR_FLAGS: hit = 1'b1;
            ADDR_CTRL: hit = 1'b1;
            ADDR_IRQ_STATUS: hit = 1'b1;
            ADDR_IRQ_MASK: hit = 1'b1;
            ADDR_ASSOC: hit = 1'b1;
            default: hit = 1'b0;
         endcase
         pslverr_d = !hit;
      end
      if (wr && paddr == ADDR_CTRL)
      begin
         // Software stop bits are pulses into the sticky flag, not stored.
         ctrl_d = pwdata & ~(32'(GROUPS'('1)) << CTRL_SW_LSB);
         set_v[FLAG_SW] = pwdata[CTRL_SW_LSB +: GROUPS];
      end
      if (wr && paddr == ADDR_IRQ_MASK)
         irq_mask_d = pwdata[GROUPS-1:0];
      if (wr && paddr == ADDR_ASSOC)
         assoc_d = pwdata;
      // Writing a one to bit g clears all four flags of group g together.
      if (wr && paddr == ADDR_FLAGS)
         clr = pwdata[GROUPS-1:0];
      for (int f = 0; f < FLAGS; f++)
         flag_d[f] = w1c(flag_q[f], set_v[f], clr);
      irq_st_d = w1c(irq_st_q, trip_edge,
                     (wr && paddr == ADDR_IRQ_STATUS) ? pwdata[GROUPS-1:0] : '0);
      if (rd)
      begin
         unique case (paddr)
            ADDR_FLAGS: prdata_d = {16'h0000, flag_q[FLAG_SW], flag_q[FLAG_OSC], flag_q[FLAG_REQ],
                                    flag_q[FLAG_TRIP]};
            ADDR_CTRL: prdata_d = ctrl_q;
            ADDR_IRQ_STATUS: prdata_d = {28'h0000000, irq_st_q};
            ADDR_IRQ_MASK: prdata_d = {28'h0000000, irq_mask_q};
            ADDR_ASSOC: prdata_d = assoc_q;
            default: prdata_d = ZERO_WORD;
         endcase
      end
      grp_off = flag_q[FLAG_TRIP] | flag_q[FLAG_REQ] | flag_q[FLAG_OSC] | flag_q[FLAG_SW];
      for (int c = 0; c < CHANNELS; c++)
      begin
         oea_d[c] = |(grp_off & assoc_q[c*ASSOC_STRIDE +: GROUPS]);
         oeb_d[c] = oea_d[c];
         oa_d[c] = timer_output_a_drive[c] & ~oea_d[c];
         ob_d[c] = timer_output_b_drive[c] & ~oeb_d[c];
      end
      irq_d = |(irq_st_q & irq_mask_q);
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         trip_prev_q <= '0;
         for (int f = 0; f < FLAGS; f++)
            flag_q[f] <= '0;
         ctrl_q <= {28'h0000000, CTRL_EN_RESET};
         irq_st_q <= '0;
         irq_mask_q <= IRQ_MASK_RESET;
         assoc_q <= {4{4'h0, ASSOC_RESET}};
         prdata_q <= ZERO_WORD;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         oa_q <= '0;
         ob_q <= '0;
         oea_q <= '1;
         oeb_q <= '1;
         irq_q <= 1'b0;
      end
      else if (ce)
      begin
         trip_prev_q <= trip_prev_d;
         for (int f = 0; f < FLAGS; f++)
            flag_q[f] <= flag_d[f];
         ctrl_q <= ctrl_d;
         irq_st_q <= irq_st_d;
         irq_mask_q <= irq_mask_d;
         assoc_q <= assoc_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         oa_q <= oa_d;
         ob_q <= ob_d;
         oea_q <= oea_d;
         oeb_q <= oeb_d;
         irq_q <= irq_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign timer_output_a = oa_q;
   assign timer_output_b = ob_q;
   assign timer_output_a_oe_n = oea_q;
   assign timer_output_b_oe_n = oeb_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// >>> pwm_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_model
   import odg_pkg::*;
(
   input wire logic clock, // Clock.
   input wire logic rst, // Reset.
   output logic [CHANNELS-1:0] drive_a, // Timer value, pins A.
   output logic [CHANNELS-1:0] drive_b // Timer value, pins B.
);
   // Values move every cycle so a pin stuck at its last value shows.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         drive_a <= 4'h5;
         drive_b <= 4'h3;
      end
      else
      begin
         drive_a <= ~drive_a;
         drive_b <= drive_b + 4'h1;
      end
   end
endmodule
`default_nettype wire

// >>> output_disable_group_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module odg_checker
   import odg_pkg::*;
(
   input wire logic clock, // Clock.
   input wire logic rst, // Reset.
   input wire logic psel, // Select.
   input wire logic penable, // Enable.
   input wire logic pwrite, // Write.
   input wire logic [11:0] paddr, // Address.
   input wire logic [31:0] pwdata, // Data.
   input wire logic [GROUPS-1:0] external_trip_input, // Trips.
   input wire logic osc_stop, // Osc stop.
   input wire logic [GROUPS-1:0] timer_req, // Requests.
   input wire logic [CHANNELS-1:0] timer_output_a, // Pins A.
   input wire logic [CHANNELS-1:0] timer_output_a_oe_n, // Enables A.
   input wire logic [CHANNELS-1:0] timer_output_b_oe_n, // Enables B.
   input wire logic irq // Interrupt.
);
   logic [31:0] ctl_q;
   logic [3:0] msk_q;
   wire logic wr = psel && !penable && pwrite;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Shadows of the enables; the association stays at reset in the bench.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ctl_q <= ZERO_WORD;
         msk_q <= 4'h0;
      end
      else if (wr && paddr == ADDR_CTRL)
         ctl_q <= pwdata;
      else if (wr && paddr == ADDR_IRQ_MASK)
         msk_q <= pwdata[3:0];
   end
   a_trip_hiz: assert property ($rose(|(external_trip_input & ctl_q[3:0])) |-> ##[1:5] &timer_output_a_oe_n)
      else $error("trip edge left pins driven");
   a_trip_irq: assert property ($rose(|(external_trip_input & ctl_q[3:0] & msk_q)) |-> ##[1:5] irq)
      else $error("trip edge gave no interrupt");
   a_osc_hiz: assert property ($rose(osc_stop) && |ctl_q[19:16] |-> ##[1:5] &timer_output_b_oe_n)
      else $error("osc stop left pins driven");
   a_req_hiz: assert property ($rose(|(timer_req & ctl_q[27:24])) |-> ##[1:4] &timer_output_a_oe_n)
      else $error("request left pins driven");
   a_clear_release: assert property (wr && paddr == ADDR_FLAGS && pwdata[3:0] == 4'hf && !osc_stop
      && external_trip_input == 4'h0 && timer_req == 4'h0 |-> ##[1:3] timer_output_a_oe_n == 4'h0)
      else $error("clear did not release pins");
   a_hiz_quiet: assert property ((timer_output_a & timer_output_a_oe_n) == 4'h0)
      else $error("disabled pin not quiet");
   a_pins_paired: assert property (timer_output_a_oe_n == timer_output_b_oe_n)
      else $error("pins of a channel split");
   cover property ($rose(irq));
   cover property ($rose(&timer_output_a_oe_n));
   cover property ($fell(timer_output_a_oe_n[0]));
endmodule
bind output_disable_group odg_checker u_odg_checker (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .external_trip_input, .osc_stop, .timer_req, .timer_output_a, .timer_output_a_oe_n, .timer_output_b_oe_n, .irq);
`default_nettype wire

// >>> output_disable_group_tb.sv
`timescale 1ns/1ps
`default_nettype none
module output_disable_group_tb;
   import odg_pkg::*;
   logic clock, rst, psel, penable, pwrite, osc_stop, pready, pslverr, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] trip, req, da, db, oa, oea, ob, oeb;
   int error_cnt, n_tests, cyc;
   always #2.5 clock = ~clock;
   pwm_timer_model u_pwm_timer_model (.clock(clock), .rst(rst), .drive_a(da), .drive_b(db));
   output_disable_group u_output_disable_group (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_trip_input(trip), .osc_stop(osc_stop), .timer_req(req),
      .timer_output_a_drive(da), .timer_output_b_drive(db), .timer_output_a(oa), .timer_output_a_oe_n(oea),
      .timer_output_b(ob), .timer_output_b_oe_n(oeb), .irq(irq));
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         $display("MISMATCH %s exp %h got %h", n, e, s);
         error_cnt++;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task t_regs;
      apb(0, ADDR_CTRL, 0);
      chk("ctrl", 0, rd);
      apb(0, ADDR_ASSOC, 0);
      chk("assoc", {4{4'h0, ASSOC_RESET}}, rd);
      apb(0, 12'h014, 0);
      chk("slverr", 1, er);
      chk("oe idle", 0, oea);
      $display("done regs");
   endtask
   task t_trip;
      apb(1, ADDR_CTRL, 1);
      apb(1, ADDR_IRQ_MASK, 1);
      trip <= 4'h2;
      repeat (6) @(posedge clock);
      chk("other group", 0, oea);
      trip <= 4'h3;
      repeat (6) @(posedge clock);
      chk("trip oe", 4'hf, oeb);
      chk("irq", 1, irq);
      apb(0, ADDR_FLAGS, 0);
      chk("flags", 1, rd);
      trip <= 4'h0;
      apb(1, ADDR_IRQ_STATUS, 1);
      apb(1, ADDR_FLAGS, 1);
      chk("irq off", 0, irq);
      chk("released", 0, oea);
      chk("follows", 4'(~da), oa);
      chk("follows b", 4'(db - 4'h1), ob);
      $display("done trip");
   endtask
   task t_osc;
      apb(1, ADDR_CTRL, 32'h0004_0000);
      osc_stop <= 1'b1;
      repeat (6) @(posedge clock);
      chk("osc oe", 4'hf, oea);
      apb(0, ADDR_FLAGS, 0);
      chk("osc flag", 32'h400, rd);
      osc_stop <= 1'b0;
      repeat (4) @(posedge clock);
      apb(1, ADDR_FLAGS, 4);
      chk("osc clear", 0, oea);
      $display("done osc");
   endtask
   task t_req_sw;
      apb(1, ADDR_CTRL, 32'h0800_0200);
      apb(0, ADDR_FLAGS, 0);
      chk("sw flag", 32'h2000, rd);
      req <= 4'h8;
      repeat (4) @(posedge clock);
      apb(0, ADDR_FLAGS, 0);
      chk("req flag", 32'h2080, rd);
      chk("req oe", 4'hf, oea);
      req <= 4'h0;
      apb(1, ADDR_FLAGS, 32'hf);
      apb(0, ADDR_FLAGS, 0);
      chk("all clear", 0, rd);
      $display("done req");
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial
   begin
      {clock, psel, penable, pwrite, osc_stop, paddr, pwdata, trip, req} = 0;
      rst = 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_regs();
      t_trip();
      t_osc();
      t_req_sw();
      report_and_stop();
   end
endmodule
`default_nettype wire
